// ===== hdl/bhl_params.svh
`ifndef BHL_PARAMS_SVH
`define BHL_PARAMS_SVH

// ---------------------------------------------------------------------
// Instruction fields
// ---------------------------------------------------------------------
`define BHL_F_OPC      31:26
`define BHL_F_TARGET   25:21
`define BHL_F_BASE     20:16
`define BHL_F_INDEX    15:11
`define BHL_F_DISP     15:0
`define BHL_F_XO       10:1
`define BHL_F_RC       0
`define BHL_DISP_SIGN  15
`define BHL_HALF_SIGN  15
`define BHL_F_BYTE     7:0

// ---------------------------------------------------------------------
// Encodings
// ---------------------------------------------------------------------
`define BHL_OPC_BZ     6'h22
`define BHL_OPC_BZU    6'h23
`define BHL_OPC_HA     6'h2a
`define BHL_OPC_HAU    6'h2b
`define BHL_OPC_EXT    6'h1f
`define BHL_XO_BZX     10'h057
`define BHL_XO_BZUX    10'h077
`define BHL_XO_HAX     10'h157
`define BHL_XO_HAUX    10'h177

// ---------------------------------------------------------------------
// Values
// ---------------------------------------------------------------------
`define BHL_ZERO_REG   5'h00
`define BHL_ZERO_WORD  32'h0000_0000
`define BHL_ZERO_HALF  16'h0000
`define BHL_BYTE_PAD   24'h000000

`endif

// ===== hdl/bhl_pkg.sv
package bhl_pkg;
    typedef enum logic [2:0] {
        BHL_IDLE  = 3'b000,
        BHL_RDREG = 3'b001,
        BHL_WAIT  = 3'b010,
        BHL_WBACK = 3'b011
    } bhl_state_type;
endpackage

// ===== hdl/bhl_load_unit.sv
`timescale 1ns/1ps
`include "bhl_params.svh"

module bhl_load_unit
    import bhl_pkg::*;
(
    input  wire logic        clock,         // Core clock, 40 MHz.
    input  wire logic        rst_n,         // Synchronous reset, active low.
    input  wire logic        issue_valid,   // Decode offers an instruction.
    input  wire logic [31:0] issue_instr,   // Instruction word.
    output logic             busy,          // Unit cannot take an instruction.
    output logic             unknown_op,    // Pulse: offered word is not a load of this unit.
    output logic [4:0]       rf_raddr_a,    // Base register read address.
    output logic [4:0]       rf_raddr_b,    // Index register read address.
    input  wire logic [31:0] rf_rdata_a,    // Base register contents.
    input  wire logic [31:0] rf_rdata_b,    // Index register contents.
    output logic             mem_req,       // Storage read request.
    output logic [31:0]      mem_addr,      // Effective address.
    output logic             mem_half,      // 1 halfword, 0 byte.
    input  wire logic        mem_ack,       // Storage data valid.
    input  wire logic [15:0] mem_rdata,     // Right-justified load data.
    output logic             rf_we_t,       // Target register write pulse.
    output logic [4:0]       rf_waddr_t,    // Target register address.
    output logic [31:0]      rf_wdata_t,    // Target register data.
    output logic             rf_we_b,       // Base register write pulse.
    output logic [4:0]       rf_waddr_b,    // Base register address.
    output logic [31:0]      rf_wdata_b,    // Base register data.
    output logic             done           // Pulse: instruction complete.
);

    // ---------------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------------
    logic [5:0]    opc;
    logic [9:0]    xo;
    logic          dec_ok;
    logic          dec_idx;
    logic          dec_half;
    logic          dec_upd;

    assign opc = issue_instr[`BHL_F_OPC];
    assign xo  = issue_instr[`BHL_F_XO];

    always_comb begin
        dec_ok   = 1'b1;
        dec_idx  = 1'b0;
        dec_half = 1'b0;
        dec_upd  = 1'b0;
        case (opc)
            `BHL_OPC_BZ: begin
            end
            `BHL_OPC_BZU: begin
                dec_upd = 1'b1;
            end
            `BHL_OPC_HA: begin
                dec_half = 1'b1;
            end
            `BHL_OPC_HAU: begin
                dec_half = 1'b1;
                dec_upd  = 1'b1;
            end
            `BHL_OPC_EXT: begin
                dec_idx = 1'b1;
                case (xo)
                    `BHL_XO_BZX: begin
                    end
                    `BHL_XO_BZUX: begin
                        dec_upd = 1'b1;
                    end
                    `BHL_XO_HAX: begin
                        dec_half = 1'b1;
                    end
                    `BHL_XO_HAUX: begin
                        dec_half = 1'b1;
                        dec_upd  = 1'b1;
                    end
                    default: begin
                        dec_ok = 1'b0;
                    end
                endcase
            end
            default: begin
                dec_ok = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------------
    // Captured instruction
    // ---------------------------------------------------------------------
    bhl_state_type state;
    logic [4:0]    target;
    logic [4:0]    base;
    logic [15:0]   disp;
    logic          is_idx;
    logic          is_half;
    logic          is_upd;
    logic          take;
    logic [31:0]   base_val;
    logic [31:0]   offset;

    assign take = issue_valid && !busy && state == BHL_IDLE;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            target  <= `BHL_ZERO_REG;
            base    <= `BHL_ZERO_REG;
            disp    <= `BHL_ZERO_HALF;
            is_idx  <= 1'b0;
            is_half <= 1'b0;
            is_upd  <= 1'b0;
        end else if (take && dec_ok) begin
            target  <= issue_instr[`BHL_F_TARGET];
            base    <= issue_instr[`BHL_F_BASE];
            disp    <= issue_instr[`BHL_F_DISP];
            is_idx  <= dec_idx;
            is_half <= dec_half;
            // The record bit of indexed forms is ignored; condition field zero is not written.
            is_upd  <= dec_upd;
        end
    end

    // ---------------------------------------------------------------------
    // Effective address
    // ---------------------------------------------------------------------
    assign base_val = (base == `BHL_ZERO_REG) ? `BHL_ZERO_WORD : rf_rdata_a;
    assign offset   = is_idx ? rf_rdata_b
                             : {{16{disp[`BHL_DISP_SIGN]}}, disp};

    // ---------------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state      <= BHL_IDLE;
            busy       <= 1'b0;
            unknown_op <= 1'b0;
            rf_raddr_a <= `BHL_ZERO_REG;
            rf_raddr_b <= `BHL_ZERO_REG;
            mem_req    <= 1'b0;
            mem_addr   <= `BHL_ZERO_WORD;
            mem_half   <= 1'b0;
            done       <= 1'b0;
        end else begin
            unknown_op <= 1'b0;
            done       <= 1'b0;
            case (state)
                BHL_IDLE: begin
                    if (take && dec_ok) begin
                        rf_raddr_a <= issue_instr[`BHL_F_BASE];
                        rf_raddr_b <= issue_instr[`BHL_F_INDEX];
                        busy       <= 1'b1;
                        state      <= BHL_RDREG;
                    end else if (take) begin
                        unknown_op <= 1'b1;
                    end
                end
                BHL_RDREG: begin
                    // Invalid update encodings take the same path and never hold the pipe.
                    mem_addr <= base_val + offset;
                    mem_half <= is_half;
                    mem_req  <= 1'b1;
                    state    <= BHL_WAIT;
                end
                BHL_WAIT: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        done    <= 1'b1;
                        state   <= BHL_WBACK;
                    end
                end
                BHL_WBACK: begin
                    busy  <= 1'b0;
                    state <= BHL_IDLE;
                end
                default: begin
                    busy    <= 1'b0;
                    mem_req <= 1'b0;
                    state   <= BHL_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------------
    // Register write-back
    // ---------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rf_we_t    <= 1'b0;
            rf_waddr_t <= `BHL_ZERO_REG;
            rf_wdata_t <= `BHL_ZERO_WORD;
            rf_we_b    <= 1'b0;
            rf_waddr_b <= `BHL_ZERO_REG;
            rf_wdata_b <= `BHL_ZERO_WORD;
        end else begin
            rf_we_t <= 1'b0;
            rf_we_b <= 1'b0;
            if (state == BHL_WAIT && mem_ack) begin
                rf_we_t    <= 1'b1;
                rf_waddr_t <= target;
                if (is_half) begin
                    rf_wdata_t <= {{16{mem_rdata[`BHL_HALF_SIGN]}}, mem_rdata};
                end else begin
                    rf_wdata_t <= {`BHL_BYTE_PAD, mem_rdata[`BHL_F_BYTE]};
                end
                // With base equal to target in an update form both ports fire; the result is left to the file.
                rf_we_b    <= is_upd;
                rf_waddr_b <= base;
                rf_wdata_b <= mem_addr;
            end
        end
    end

    // ---------------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------------
    sequence s_address_cycle;
        state == BHL_RDREG;
    endsequence

    sequence s_ack_taken;
        state == BHL_WAIT && mem_ack;
    endsequence

    property p_disp_ea;
        @(posedge clock) disable iff (!rst_n)
        s_address_cycle ##0 (!is_idx && base != `BHL_ZERO_REG) |=>
            mem_addr == $past(rf_rdata_a) + {{16{$past(disp[`BHL_DISP_SIGN])}}, $past(disp)};
    endproperty
    a_disp_ea: assert property (p_disp_ea) else $error("displacement address wrong");

    property p_zero_base;
        @(posedge clock) disable iff (!rst_n)
        s_address_cycle ##0 (base == `BHL_ZERO_REG) |=>
            mem_addr == $past(offset) && mem_req;
    endproperty
    a_zero_base: assert property (p_zero_base) else $error("zero base not used");

    property p_idx_ea;
        @(posedge clock) disable iff (!rst_n)
        s_address_cycle ##0 (is_idx && base != `BHL_ZERO_REG) |=>
            mem_addr == $past(rf_rdata_a) + $past(rf_rdata_b);
    endproperty
    a_idx_ea: assert property (p_idx_ea) else $error("indexed address wrong");

    property p_byte_zero;
        @(posedge clock) disable iff (!rst_n)
        s_ack_taken ##0 !is_half |=>
            rf_we_t && rf_wdata_t == {`BHL_BYTE_PAD, $past(mem_rdata[`BHL_F_BYTE])};
    endproperty
    a_byte_zero: assert property (p_byte_zero) else $error("byte not zero extended");

    property p_half_sign;
        @(posedge clock) disable iff (!rst_n)
        s_ack_taken ##0 is_half |=>
            rf_we_t && rf_wdata_t[15:0] == $past(mem_rdata) && rf_wdata_t[31:16] == {16{rf_wdata_t[15]}};
    endproperty
    a_half_sign: assert property (p_half_sign) else $error("halfword not sign extended");

    property p_update;
        @(posedge clock) disable iff (!rst_n)
        rf_we_t |-> rf_we_b == is_upd && (!rf_we_b || (rf_wdata_b == mem_addr && rf_waddr_b == base));
    endproperty
    a_update: assert property (p_update) else $error("base update wrong");

    property p_record_completes;
        @(posedge clock) disable iff (!rst_n)
        take && dec_ok && dec_idx && issue_instr[`BHL_F_RC] |=> ##1 mem_req;
    endproperty
    a_record_completes: assert property (p_record_completes) else $error("record form stalled");

    property p_no_stall;
        @(posedge clock) disable iff (!rst_n)
        s_ack_taken |=> done && rf_we_t ##1 !busy;
    endproperty
    a_no_stall: assert property (p_no_stall) else $error("completion stalled");

endmodule

// ===== test/bhl_store_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Storage side: answers each read after zero or three wait cycles
// ---------------------------------------------------------------------
module bhl_store_model (
    input  wire logic        clock,      // Core clock.
    input  wire logic        slow,       // High adds wait cycles.
    input  wire logic        mem_req,    // Read request.
    input  wire logic [31:0] mem_addr,   // Effective address.
    output logic             mem_ack,    // Data valid pulse.
    output logic [15:0]      mem_rdata   // Right-justified data.
);
    int wait_count;

    // Outside the ack cycle the data lines show the inverse of the last value.
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 16'h0000;
        wait_count = 0;
        forever begin
            @(posedge clock);
            #1;
            if (mem_ack === 1'b1) begin
                mem_ack = 1'b0;
                mem_rdata = ~mem_rdata;
                wait_count = 0;
            end else if (mem_req === 1'b1 && wait_count >= (slow ? 3 : 0)) begin
                mem_ack = 1'b1;
                mem_rdata = mem_addr[15:0] ^ 16'h9c3a;
            end else if (mem_req === 1'b1) begin
                wait_count++;
            end
        end
    end
endmodule

// ===== test/tb_bhl_load_unit.sv
`timescale 1ns/1ps
`include "bhl_params.svh"

module tb_bhl_load_unit;
    logic        clock, rst_n, issue_valid, slow, busy, unknown_op, mem_req, mem_half, mem_ack;
    logic        rf_we_t, rf_we_b, done;
    logic [31:0] issue_instr, rf_rdata_a, rf_rdata_b, mem_addr, rf_wdata_t, rf_wdata_b;
    logic [4:0]  rf_raddr_a, rf_raddr_b, rf_waddr_t, rf_waddr_b;
    logic [15:0] mem_rdata;
    int          err_count, checks;

    function automatic logic [31:0] regval(input logic [4:0] n);
        return {11'h001, n, 16'h0130};
    endfunction

    assign rf_rdata_a = regval(rf_raddr_a);
    assign rf_rdata_b = regval(rf_raddr_b);

    bhl_load_unit u_dut (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid), .issue_instr(issue_instr),
        .busy(busy), .unknown_op(unknown_op), .rf_raddr_a(rf_raddr_a), .rf_raddr_b(rf_raddr_b),
        .rf_rdata_a(rf_rdata_a), .rf_rdata_b(rf_rdata_b), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_half(mem_half), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rf_we_t(rf_we_t),
        .rf_waddr_t(rf_waddr_t), .rf_wdata_t(rf_wdata_t), .rf_we_b(rf_we_b), .rf_waddr_b(rf_waddr_b),
        .rf_wdata_b(rf_wdata_b), .done(done));

    bhl_store_model u_store (.clock(clock), .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge clock);
        #1;
    endtask

    // Issues one load and judges address and size, and both write ports only when strict is set.
    task automatic run_load(input logic [31:0] ins, input logic half, input logic upd, input logic xf,
                            input logic strict);
        logic [31:0] ea;
        logic [15:0] raw;
        int          n;
        ea = (ins[20:16] == 5'h00) ? 32'h0000_0000 : regval(ins[20:16]);
        ea = ea + (xf ? regval(ins[15:11]) : {{16{ins[15]}}, ins[15:0]});
        raw = ea[15:0] ^ 16'h9c3a;
        for (n = 0; n < 20 && busy !== 1'b0; n++) step();
        issue_valid = 1'b1;
        issue_instr = ins;
        step();
        issue_valid = 1'b0;
        for (n = 0; n < 20 && mem_req !== 1'b1; n++) step();
        chk(mem_addr, ea);
        chk({31'h0, mem_half}, {31'h0, half});
        for (n = 0; n < 20 && done !== 1'b1; n++) step();
        chk({31'h0, done}, 32'h0000_0001);
        if (strict) begin
            chk({31'h0, rf_we_t}, 32'h0000_0001);
            chk({27'h0, rf_waddr_t}, {27'h0, ins[25:21]});
            chk(rf_wdata_t, half ? {{16{raw[15]}}, raw} : {24'h0, raw[7:0]});
            chk({31'h0, rf_we_b}, {31'h0, upd});
            if (upd) chk({27'h0, rf_waddr_b}, {27'h0, ins[20:16]});
            if (upd) chk(rf_wdata_b, ea);
        end
    endtask

    task automatic test_reset();
        chk({28'h0, busy, mem_req, done, rf_we_t}, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic test_dform();
        logic [5:0] opc [4];
        opc = '{`BHL_OPC_BZ, `BHL_OPC_BZU, `BHL_OPC_HA, `BHL_OPC_HAU};
        for (int i = 0; i < 4; i++) run_load({opc[i], 5'h05, 5'h03, 16'hfff0}, i[1], i[0], 1'b0, 1'b1);
        run_load({`BHL_OPC_BZ, 5'h06, 5'h00, 16'h7ff1}, 1'b0, 1'b0, 1'b0, 1'b1);
        run_load({`BHL_OPC_HA, 5'h06, 5'h00, 16'h0c4e}, 1'b1, 1'b0, 1'b0, 1'b1);
        $display("test dform done");
    endtask

    task automatic test_xform();
        logic [9:0] xo [4];
        xo = '{`BHL_XO_BZX, `BHL_XO_BZUX, `BHL_XO_HAX, `BHL_XO_HAUX};
        for (int i = 0; i < 4; i++)
            run_load({`BHL_OPC_EXT, 5'h07, 5'h02, 5'h09, xo[i], 1'b1}, i[1], i[0], 1'b1, 1'b1);
        run_load({`BHL_OPC_EXT, 5'h07, 5'h00, 5'h1f, `BHL_XO_HAX, 1'b0}, 1'b1, 1'b0, 1'b1, 1'b1);
        $display("test xform done");
    endtask

    task automatic test_unknown();
        logic [31:0] ops [2];
        logic        seen, req;
        ops = '{{6'h20, 26'h0}, {`BHL_OPC_EXT, 15'h0, 10'h117, 1'b0}};
        foreach (ops[k]) begin
            // An offer made while busy is ignored, so wait for the unit to drain first.
            for (int n = 0; n < 20 && busy !== 1'b0; n++) step();
            seen = 1'b0;
            req = 1'b0;
            issue_valid = 1'b1;
            issue_instr = ops[k];
            step();
            issue_valid = 1'b0;
            repeat (4) begin
                seen = seen | unknown_op;
                req = req | mem_req | rf_we_t | rf_we_b;
                step();
            end
            chk({31'h0, seen}, 32'h0000_0001);
            chk({31'h0, req}, 32'h0000_0000);
        end
        $display("test unknown done");
    endtask

    task automatic test_invalid_and_slow();
        run_load({`BHL_OPC_BZU, 5'h04, 5'h00, 16'h0010}, 1'b0, 1'b1, 1'b0, 1'b0);
        run_load({`BHL_OPC_EXT, 5'h08, 5'h08, 5'h01, `BHL_XO_HAUX, 1'b0}, 1'b1, 1'b1, 1'b1, 1'b0);
        slow = 1'b1;
        run_load({`BHL_OPC_HAU, 5'h0a, 5'h1e, 16'h8002}, 1'b1, 1'b1, 1'b0, 1'b1);
        run_load({`BHL_OPC_EXT, 5'h0b, 5'h1e, 5'h03, `BHL_XO_BZX, 1'b0}, 1'b0, 1'b0, 1'b1, 1'b1);
        slow = 1'b0;
        $display("test invalid and slow done");
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        #100000;
        err_count++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        issue_valid = 1'b0;
        issue_instr = 32'h0000_0000;
        slow = 1'b0;
        err_count = 0;
        checks = 0;
        repeat (10) step();
        rst_n = 1'b1;
        step();
        test_reset();
        test_dform();
        test_xform();
        test_unknown();
        test_invalid_and_slow();
        conclude();
    end
endmodule
